// ==== design/iack_pkg.sv ====
// Purpose: Shared constants for the interrupt-acknowledge read path
// Assumes: 32-bit processor data, four byte lanes
// Notes: Trigger register address is fixed by the bridge map
package iack_pkg;
   localparam logic [31:0] IACK_TRIGGER_ADDR = 32'hFEFF0030;
   localparam logic [31:0] IACK_TRIGGER_RESET = 32'h00000000;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam logic [3:0] PCI_CMD_IACK = 4'h0;
   localparam logic [3:0] PCI_CMD_IDLE = 4'hF;
   localparam logic [3:0] BE_NONE = 4'h0;
endpackage : iack_pkg

// ==== design/iack_sync_bit.sv ====
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level held until acknowledged
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module iack_sync_bit (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset
   input wire logic d, // Level from other domain
   output logic q // Synchronised level
);
   logic meta;
   // Two stages to settle metastability
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : iack_sync_bit

// ==== design/iack_pci_side.sv ====
// Purpose: PCI-clock end issuing one interrupt acknowledge cycle per request toggle
// Assumes: Target answers with ready; no retry or abort handling
// Notes: Request arrives as a toggle, completion leaves as a toggle
`timescale 1ns/1ps
module iack_pci_side
   import iack_pkg::*;
(
   input wire logic pci_clk, // Link clock
   input wire logic pci_rst, // Reset on link clock
   input wire logic req_tgl, // Request toggle from core
   input wire logic [3:0] be_hold, // Stable byte enables from core
   input wire logic trdy, // Target ready from controller (synchronised here)
   input wire logic [31:0] ad_in, // Vector from controller
   output logic [3:0] cbe, // Command then byte enables
   output logic frame, // Cycle in progress
   output logic [31:0] vector, // Captured vector
   output logic done_tgl // Completion toggle to core
);
   typedef enum logic [1:0] {P_IDLE, P_ADDR, P_DATA} pstate_e;
   pstate_e state;
   logic req_s;
   logic req_seen;
   logic trdy_s;
   logic trdy_m;
   wire new_req = req_s != req_seen;
   iack_sync_bit u_req (.clk(pci_clk), .rst(pci_rst), .d(req_tgl), .q(req_s));
   // Target ready double-flopped as a pin input
   always_ff @(posedge pci_clk) begin
      if (pci_rst) begin
         trdy_m <= 1'b0;
         trdy_s <= 1'b0;
      end else begin
         trdy_m <= trdy;
         trdy_s <= trdy_m;
      end
   end
   // One cycle per toggle; byte enables stable while core waits
   always_ff @(posedge pci_clk) begin
      if (pci_rst) begin
         state <= P_IDLE;
         req_seen <= 1'b0;
         cbe <= PCI_CMD_IDLE;
         frame <= 1'b0;
         vector <= IACK_TRIGGER_RESET;
         done_tgl <= 1'b0;
      end else begin
         case (state)
            P_IDLE: begin
               if (new_req) begin
                  // [RQ2] single acknowledge issue
                  req_seen <= req_s;
                  frame <= 1'b1;
                  cbe <= PCI_CMD_IACK;
                  state <= P_ADDR;
               end
            end
            P_ADDR: begin
               // [RQ4] pass processor enables
               cbe <= be_hold;
               state <= P_DATA;
            end
            P_DATA: begin
               if (trdy_s) begin
                  // Vector latched; ad_in assumed held with trdy
                  vector <= ad_in;
                  frame <= 1'b0;
                  cbe <= PCI_CMD_IDLE;
                  done_tgl <= ~done_tgl;
                  state <= P_IDLE;
               end
            end
            default: state <= P_IDLE;
         endcase
      end
   end
endmodule : iack_pci_side

// ==== design/iack_read_path.sv ====
// Purpose: Interrupt-acknowledge trigger register on the processor side of the bridge
// Assumes: Processor read strobe is one cycle; read stays pending until RD_ACK
// Notes: Link logic runs on PCI_CLK; crossings use toggles and stable holding words
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Trigger register is read-only, loaded only from acknowledge result; RD_DATA also loads zero on unmapped reads.
// [RQ2] Each trigger read issues exactly one PCI interrupt acknowledge cycle.
// [RQ3] Any byte lane subset may be read from the trigger register.
// [RQ4] Acknowledge cycle drives the processor's byte enable pattern.
// [RQ5] Returned vector becomes the read data of the pending read.
// [RQ6] Read completion held off until acknowledge cycle finishes.
module iack_read_path
   import iack_pkg::*;
(
   input wire logic CORE_CLK, // Core clock 250 MHz
   input wire logic RST, // Synchronous reset, core domain
   input wire logic RD_REQ, // Processor read strobe, one cycle
   input wire logic WR_REQ, // Processor write strobe, one cycle
   input wire logic [31:0] ADDR, // Processor byte address
   input wire logic [3:0] BE, // Processor byte lanes, 1 = selected
   output logic RD_ACK, // Read complete pulse
   output logic WR_ACK, // Write complete pulse (ignored data)
   output logic [31:0] RD_DATA, // Read data
   output logic BUSY, // Acknowledge pending
   input wire logic PCI_CLK, // PCI link clock
   input wire logic PCI_RST, // Synchronous reset, PCI domain
   input wire logic PCI_TRDY, // Target ready from controller
   input wire logic [31:0] PCI_AD_IN, // Vector driven by controller
   output logic [3:0] PCI_CBE, // Command and byte enables
   output logic PCI_FRAME // Acknowledge cycle active
);
   logic pending;
   logic req_tgl;
   logic [3:0] be_hold;
   logic done_seen;
   logic done_s;
   logic [31:0] pci_vector;
   logic pci_done_tgl;
   // Address decode used by the read path only; writes are acknowledged at any address
   wire hit = ADDR == IACK_TRIGGER_ADDR;
   wire start_rd = RD_REQ && hit && !pending;
   wire done_evt = done_s != done_seen;
   // Byte lanes outside the read mask return zero
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : lane_mask

   iack_sync_bit u_done (.clk(CORE_CLK), .rst(RST), .d(pci_done_tgl), .q(done_s));

   iack_pci_side u_pci (
      .pci_clk(PCI_CLK),
      .pci_rst(PCI_RST),
      .req_tgl(req_tgl),
      .be_hold(be_hold),
      .trdy(PCI_TRDY),
      .ad_in(PCI_AD_IN),
      .cbe(PCI_CBE),
      .frame(PCI_FRAME),
      .vector(pci_vector),
      .done_tgl(pci_done_tgl)
   );

   // Request launch; be_hold is stable until completion, so it crosses safely
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pending <= 1'b0;
         req_tgl <= 1'b0;
         be_hold <= BE_NONE;
         done_seen <= 1'b0;
      end else begin
         done_seen <= done_s;
         if (start_rd) begin
            // [RQ3] any lane subset
            be_hold <= BE;
            // [RQ2] one toggle per read
            req_tgl <= ~req_tgl;
            pending <= 1'b1;
         end else if (done_evt) begin
            pending <= 1'b0;
         end
      end
   end

   // Result capture; RD_DATA is the trigger register as software sees it
   // Vector word is stable once the done toggle is seen, so no second copy is kept
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         RD_ACK <= 1'b0;
         RD_DATA <= IACK_TRIGGER_RESET;
         WR_ACK <= 1'b0;
      end else begin
         // [RQ1] writes complete but never load
         WR_ACK <= WR_REQ;
         // [RQ6] trigger-read ack only after completion; unmapped reads ack the cycle after the strobe
         RD_ACK <= (pending && done_evt) || (RD_REQ && !hit);
         if (pending && done_evt) begin
            // [RQ5] vector returned as data
            RD_DATA <= pci_vector & lane_mask(be_hold);
         end else if (RD_REQ && !hit) begin
            RD_DATA <= IACK_TRIGGER_RESET; // Unmapped reads return zero
         end
      end
   end

   assign BUSY = pending;
endmodule : iack_read_path

// ==== test/iack_ctrl_model.sv ====
// Purpose: Interrupt controller answering acknowledge cycles
// Assumes: Vector and wait count set by the bench, wait_n of 1 or more
// Notes: Released vector lines toggle so stale data never looks valid
`timescale 1ns/1ps
module iack_ctrl_model (
   input wire logic pci_clk, // Link clock
   input wire logic frame, // Cycle active
   input wire logic [31:0] vec, // Vector to return
   input wire logic [3:0] wait_n, // Wait states
   output logic trdy, // Target ready
   output logic [31:0] ad // Vector lines
);
   logic [3:0] cnt = 4'h0;
   initial trdy = 1'b0;
   initial ad = 32'h0;
   // Unknown frame before link reset counts as idle
   wire act = frame === 1'b1;
   // Ready after wait_n edges, held with the vector until frame drops
   always @(posedge pci_clk) begin
      cnt <= act ? cnt + 4'h1 : 4'h0;
      trdy <= act && (trdy || cnt == wait_n);
      ad <= (act && (trdy || cnt == wait_n)) ? vec : ~ad;
   end
endmodule : iack_ctrl_model

// ==== test/iack_read_path_chk.sv ====
// Purpose: Port checker for the acknowledge read path
// Assumes: Both resets synchronous, active high
// Notes: Lanes and vector are captured here, not taken from the design
`timescale 1ns/1ps
module iack_read_path_chk
   import iack_pkg::*;
(
   input wire logic CORE_CLK, // Core clock
   input wire logic RST, // Core reset
   input wire logic RD_REQ, // Read strobe
   input wire logic [31:0] ADDR, // Address
   input wire logic [3:0] BE, // Lanes
   input wire logic RD_ACK, // Read done
   input wire logic [31:0] RD_DATA, // Read data
   input wire logic BUSY, // Pending
   input wire logic PCI_CLK, // Link clock
   input wire logic PCI_RST, // Link reset
   input wire logic PCI_TRDY, // Target ready
   input wire logic [31:0] PCI_AD_IN, // Vector
   input wire logic [3:0] PCI_CBE, // Command, lanes
   input wire logic PCI_FRAME // Cycle active
);
   logic [3:0] be_q;
   logic [31:0] vec_q;
   wire hit = RD_REQ && ADDR == IACK_TRIGGER_ADDR && !BUSY;
   wire [31:0] mask = {{8{be_q[3]}}, {8{be_q[2]}}, {8{be_q[1]}}, {8{be_q[0]}}};
   // Lanes of the accepted read, held while it is pending
   always_ff @(posedge CORE_CLK) begin
      if (hit) be_q <= BE;
   end
   // Vector as the target hands it over
   always_ff @(posedge PCI_CLK) begin
      if (PCI_FRAME && PCI_TRDY) vec_q <= PCI_AD_IN;
   end
   a_read_goes_busy:
      assert property (@(posedge CORE_CLK) disable iff (RST) hit |=> BUSY) else $error("busy not set");
   a_ack_ends_wait:
      assert property (@(posedge CORE_CLK) disable iff (RST) $fell(BUSY) |-> RD_ACK) else $error("no ack");
   a_data_only_ack:
      assert property (@(posedge CORE_CLK) disable iff (RST) $changed(RD_DATA) |-> RD_ACK) else $error("data moved");
   a_read_starts_cycle:
      assert property (@(posedge CORE_CLK) disable iff (RST) hit |-> ##[1:40] PCI_FRAME) else $error("no cycle");
   a_cmd_first:
      assert property (@(posedge PCI_CLK) disable iff (PCI_RST)
         $rose(PCI_FRAME) |-> PCI_CBE == PCI_CMD_IACK) else $error("bad command");
   a_lanes_passed:
      assert property (@(posedge PCI_CLK) disable iff (PCI_RST)
         $rose(PCI_FRAME) |=> PCI_CBE == be_q) else $error("bad lanes");
   a_vector_returned:
      assert property (@(posedge CORE_CLK) disable iff (RST)
         $fell(BUSY) |-> RD_DATA == (vec_q & mask)) else $error("bad vector");
   c_trigger: cover property (@(posedge CORE_CLK) hit);
   c_slow: cover property (@(posedge PCI_CLK) PCI_FRAME [*8]);
   c_done: cover property (@(posedge CORE_CLK) $fell(BUSY));
endmodule : iack_read_path_chk
bind iack_read_path iack_read_path_chk u_chk (.CORE_CLK, .RST, .RD_REQ, .ADDR, .BE, .RD_ACK, .RD_DATA, .BUSY,
   .PCI_CLK, .PCI_RST, .PCI_TRDY, .PCI_AD_IN, .PCI_CBE, .PCI_FRAME);

// ==== test/pci_interrupt_ack_read_path_bench.sv ====
// Purpose: Self-checking bench for the acknowledge read path
// Assumes: Inputs change on the falling core edge
// Notes: Frames and data-phase lanes are watched on the link
`timescale 1ns/1ps
module pci_interrupt_ack_read_path_bench;
   import iack_pkg::*;
   logic clk = 1'b0, pclk = 1'b0, rst = 1'b1, prst = 1'b1, rd = 1'b0, wr = 1'b0, fq = 1'b0;
   logic [31:0] addr = 32'h0, vec = 32'h0, tr_ad, rdata;
   logic [3:0] be = 4'h0, wn = 4'h1, cbe, seen_be;
   logic ack, wack, busy, trdy, frame;
   int failures = 0, tests_run = 0, frames = 0;
   always #2 clk = ~clk;
   // Link clock offset so its rising edge falls 1 ns after a core rising edge, eight core cycles per link cycle
   initial begin
      #7;
      forever #16 pclk = ~pclk;
   end
   iack_read_path u_iack_read_path (.CORE_CLK(clk), .RST(rst), .RD_REQ(rd), .WR_REQ(wr), .ADDR(addr), .BE(be),
      .RD_ACK(ack), .WR_ACK(wack), .RD_DATA(rdata), .BUSY(busy), .PCI_CLK(pclk), .PCI_RST(prst),
      .PCI_TRDY(trdy), .PCI_AD_IN(tr_ad), .PCI_CBE(cbe), .PCI_FRAME(frame));
   iack_ctrl_model u_iack_ctrl_model (.pci_clk(pclk), .frame(frame), .vec(vec), .wait_n(wn), .trdy(trdy),
      .ad(tr_ad));
   // Count cycles and keep the data-phase lanes
   always @(posedge pclk) begin
      fq <= frame;
      if (frame && !fq) frames <= frames + 1;
      if (frame && fq) seen_be <= cbe;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   function automatic logic [31:0] lm(input logic [3:0] b);
      lm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction : lm
   // One access; the answer is awaited under a bound
   task automatic access(input logic w, input logic [31:0] a, input logic [3:0] b);
      int n;
      @(negedge clk);
      rd = !w;
      wr = w;
      addr = a;
      be = b;
      @(negedge clk);
      rd = 1'b0;
      wr = 1'b0;
      n = 0;
      while (n < 200 && ack !== 1'b1 && wack !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      check({31'h0, n < 200}, 32'h1);
   endtask : access
   task automatic t_reset;
      check({busy, frame, cbe}, 6'h0F);
      check(rdata, IACK_TRIGGER_RESET);
      $display("test reset done");
   endtask : t_reset
   task automatic t_lanes;
      logic [3:0] tbl [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hF};
      int f0;
      foreach (tbl[i]) begin
         vec = 32'hA5C31E78 ^ i;
         f0 = frames;
         access(1'b0, IACK_TRIGGER_ADDR, tbl[i]);
         check(rdata, vec & lm(tbl[i]));
         check({28'h0, seen_be}, {28'h0, tbl[i]});
         check(frames - f0, 1);
      end
      $display("test lanes done");
   endtask : t_lanes
   task automatic t_slow;
      wn = 4'h9;
      vec = 32'h5A3C96E1;
      access(1'b1, IACK_TRIGGER_ADDR, 4'hF);
      check(rdata, 32'hA5C31E78 ^ 32'h5);
      access(1'b0, IACK_TRIGGER_ADDR, 4'hF);
      check({31'h0, frame}, 32'h0);
      check(rdata, vec);
      access(1'b0, IACK_TRIGGER_ADDR + 32'h4, 4'hF);
      check(rdata, 32'h0);
      check(frames, 7);
      $display("test slow done");
   endtask : t_slow
   task automatic tally_and_finish;
      $display("checks=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(posedge pclk);
      @(negedge clk);
      prst = 1'b0;
      t_reset();
      t_lanes();
      t_slow();
      tally_and_finish();
   end
endmodule : pci_interrupt_ack_read_path_bench
